// ### verilog/hsecfg_top.sv
/*
  Startup configuration and channel-enable logic of a four-channel hot-swap
  controller: strap capture, enable default, grouping, protection mode,
  host rewrite of enable bits, critical-fault response and monitor capture.
  Assumes analog comparators for supply-good and on-pins, pre-decoded
  three-level straps, a host port already on mclk, and ADC results on mclk.
*/
`default_nettype none
module hsecfg_top
  import hsecfg_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // Analog comparator results
  input  wire logic           supply_good,
  input  wire logic [3:0]     on_cmp,
  // Pre-decoded straps
  input  wire logic           enable_strap_pin,
  input  wire hsecfg_tri_t    grouping_strap,
  input  wire hsecfg_tri_t    protection_strap_pin,
  // Host writes and read-back
  input  wire hsecfg_hostwr_t host_wr,
  output logic [3:0]          software_enable_bit,
  output logic [3:0]          hardware_default_enable_bit,
  output logic [3:0]          on_status,
  // Critical fault inputs per channel
  input  wire logic [3:0]     crit_fault,
  // Monitor samples in
  input  wire hsecfg_mon_t [3:0] mon_in,
  // Channel control and status
  output logic [3:0]          gate_drive,
  output logic [3:0]          power_good_drop,
  output logic                alert_out,
  output logic                config_loaded,
  output hsecfg_grp_t         grouping_mode,
  output hsecfg_protection_strap_pin_t        protection_mode,
  output hsecfg_mon_t [3:0]   mon_out
);

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins

  logic [3:0]  on_s;
  logic        supply_s;
  logic        en_strap_s;
  hsecfg_tri_t grp_s;
  hsecfg_tri_t protection_strap_pin_s;

  hsecfg_sync2 #(.W(4)) u_sync_on (
    .mclk (mclk),
    .nrst (nrst),
    .d    (on_cmp),
    .q    (on_s)
  );

  // Supply-good and straps share one synchroniser: 1 + 1 + 3 + 3 bits.
  // Straps are static, so skew between their bits does not matter; the
  // one-shot capture below only reads them after the pipeline has filled.
  hsecfg_sync2 #(.W(8)) u_sync_straps (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({supply_good, enable_strap_pin, grouping_strap,
            protection_strap_pin}),
    .q    ({supply_s, en_strap_s, grp_s, protection_strap_pin_s})
  );

  //////////////////////////////////////////////////////////////////////////
  // Startup sequencer

  hsecfg_state_t state_r;
  hsecfg_state_t state_nxt;
  logic          sampled_r;

  // Straps are read the first clock they are valid after release; the
  // synchroniser output is already reset-clean by then.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HSECFG_ST_WAIT_SUPPLY: if (supply_s && sampled_r) begin
        state_nxt = HSECFG_ST_LOAD;
      end
      HSECFG_ST_LOAD: state_nxt = HSECFG_ST_RUN;
      HSECFG_ST_RUN: if (!supply_s) begin
        state_nxt = HSECFG_ST_WAIT_SUPPLY;
      end
      default: state_nxt = HSECFG_ST_WAIT_SUPPLY;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= HSECFG_ST_WAIT_SUPPLY;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // One-shot strap capture

  logic        sync_ready_r;
  logic [1:0]  sync_cnt_r;
  hsecfg_grp_t  grp_r;
  hsecfg_protection_strap_pin_t protection_strap_pin_r;
  logic         en_strap_r;

  // Two edges of pipeline fill before synchroniser output is trustworthy
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync_cnt_r   <= 2'h0;
      sync_ready_r <= 1'b0;
    end else if (!sync_ready_r) begin
      sync_cnt_r   <= sync_cnt_r + 2'h1;
      sync_ready_r <= (sync_cnt_r == 2'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sampled_r  <= 1'b0;
      grp_r      <= HSECFG_GRP_INDEP;
      protection_strap_pin_r     <= HSECFG_PROTECTION_STRAP_PIN_ALERT_PG;
      en_strap_r <= 1'b0;
    end else if (sync_ready_r && !sampled_r) begin
      sampled_r  <= 1'b1;
      en_strap_r <= en_strap_s;
      if (grp_s.high) begin
        grp_r <= HSECFG_GRP_PAIRED;
      end else if (grp_s.low) begin
        grp_r <= HSECFG_GRP_INDEP;
      end else begin
        grp_r <= HSECFG_GRP_ALL;
      end
      if (protection_strap_pin_s.high) begin
        protection_strap_pin_r <= HSECFG_PROTECTION_STRAP_PIN_ALERT_PG;
      end else if (protection_strap_pin_s.low) begin
        protection_strap_pin_r <= HSECFG_PROTECTION_STRAP_PIN_SHUTDOWN;
      end else begin
        protection_strap_pin_r <= HSECFG_PROTECTION_STRAP_PIN_ALERT_ONLY;
      end
    end
  end
  // No other path writes grp_r or protection_strap_pin_r after capture.

  assign grouping_mode   = grp_r;
  assign protection_mode = protection_strap_pin_r;
  assign config_loaded   = (state_r == HSECFG_ST_RUN);

  //////////////////////////////////////////////////////////////////////////
  // Enable bits

  logic [3:0] sw_en_r;
  logic [3:0] hw_en_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hw_en_r <= HSECFG_EN_RST;
    end else if (state_r == HSECFG_ST_LOAD) begin
      hw_en_r <= en_strap_r ? HSECFG_ALL_ON : HSECFG_EN_RST;
    end else if (state_r == HSECFG_ST_RUN && host_wr.wr) begin
      // Strap is not looked at here.
      hw_en_r <= (hw_en_r & ~host_wr.hw_mask)
               | (host_wr.hw_en & host_wr.hw_mask);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sw_en_r <= HSECFG_EN_RST;
    end else if (state_r == HSECFG_ST_RUN && host_wr.wr) begin
      sw_en_r <= host_wr.sw_en;
    end
  end

  assign software_enable_bit         = sw_en_r;
  assign hardware_default_enable_bit = hw_en_r;

  //////////////////////////////////////////////////////////////////////////
  // Channel enable and grouping

  logic [3:0] on_r;
  logic [3:0] ch_ok;
  logic [3:0] grp_ok;
  logic [3:0] shut_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      on_r <= 4'h0;
    end else begin
      on_r <= on_s;
    end
  end
  assign on_status = on_r;

  // Software enable is 0 at startup, so this reduces to hw enable and on.
  assign ch_ok = on_r & (sw_en_r | hw_en_r);

  always_comb begin
    unique case (grp_r)
      HSECFG_GRP_PAIRED: begin
        grp_ok[0] = ch_ok[0] & ch_ok[2];
        grp_ok[2] = ch_ok[0] & ch_ok[2];
        grp_ok[1] = ch_ok[1] & ch_ok[3];
        grp_ok[3] = ch_ok[1] & ch_ok[3];
      end
      HSECFG_GRP_ALL: grp_ok = {4{&ch_ok}};
      default: grp_ok = ch_ok;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gate_drive <= 4'h0;
    end else if (state_r != HSECFG_ST_RUN) begin
      gate_drive <= 4'h0;
    end else begin
      gate_drive <= grp_ok & ~shut_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Critical fault response

  // Fault inputs are already on mclk, so one stage is enough; gating with
  // config_loaded keeps a fault seen during startup from raising alert.

  logic [3:0] fault_s;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fault_s <= 4'h0;
    end else begin
      fault_s <= crit_fault & {4{config_loaded}};
    end
  end

  // Shutdown latches until the channel's enable condition drops, which
  // gives software a way to restart by toggling an enable bit.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shut_r          <= 4'h0;
      power_good_drop <= 4'h0;
      alert_out       <= 1'b0;
    end else begin
      alert_out       <= |fault_s;
      power_good_drop <= (protection_strap_pin_r == HSECFG_PROTECTION_STRAP_PIN_ALERT_ONLY) ? 4'h0
                         : fault_s;
      if (protection_strap_pin_r == HSECFG_PROTECTION_STRAP_PIN_SHUTDOWN) begin
        shut_r <= (shut_r & grp_ok) | fault_s;
      end else begin
        shut_r <= 4'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Monitor capture

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mon_out <= '0;
    end else begin
      for (int i = 0; i < HSECFG_NCH; i++) begin
        mon_out[i].valid <= 1'b0;
        if (mon_in[i].valid && gate_drive[i]) begin
          mon_out[i] <= mon_in[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/hsecfg_pkg.sv
/*
  Package for the hot-swap enable and startup configuration block:
  channel count, strap encodings, grouping and protection modes, carriers.
  Assumes three-level straps arrive already decoded into high/low/open.
*/
`default_nettype none
package hsecfg_pkg;

  localparam int unsigned HSECFG_NCH      = 4;
  localparam int unsigned HSECFG_ADC_W    = 10;
  localparam logic [3:0]  HSECFG_EN_RST   = 4'h0;
  localparam logic [3:0]  HSECFG_ALL_ON   = 4'hf;
  // Power-up supply threshold in millivolts, handled by the analog comparator
  localparam int unsigned HSECFG_PWRUP_MV = 2700;
  // On-pin comparator threshold in millivolts
  localparam int unsigned HSECFG_ON_MV    = 600;

  typedef enum logic [1:0] {
    HSECFG_GRP_INDEP  = 2'b00,
    HSECFG_GRP_PAIRED = 2'b01,
    HSECFG_GRP_ALL    = 2'b10
  } hsecfg_grp_t;

  typedef enum logic [1:0] {
    HSECFG_PROTECTION_STRAP_PIN_ALERT_PG   = 2'b00,
    HSECFG_PROTECTION_STRAP_PIN_SHUTDOWN   = 2'b01,
    HSECFG_PROTECTION_STRAP_PIN_ALERT_ONLY = 2'b10
  } hsecfg_protection_strap_pin_t;

  typedef enum logic [1:0] {
    HSECFG_ST_WAIT_SUPPLY = 2'b00,
    HSECFG_ST_LOAD        = 2'b01,
    HSECFG_ST_RUN         = 2'b10
  } hsecfg_state_t;

  // Decoded three-level strap
  typedef struct packed {
    logic high;
    logic low;
    logic open;
  } hsecfg_tri_t;

  // Software write of enable bits
  typedef struct packed {
    logic       wr;
    logic [3:0] sw_en;
    logic [3:0] hw_en;
    logic [3:0] hw_mask;
  } hsecfg_hostwr_t;

  // Per-channel monitor sample
  typedef struct packed {
    logic       valid;
    logic [9:0] current;
    logic [9:0] voltage;
  } hsecfg_mon_t;

endpackage
`default_nettype wire

// ### verilog/hsecfg_sync2.sv
/*
  Two-flop synchroniser, vector width set by parameter.
  Assumes the destination runs on mclk with synchronous active-low reset.
*/
`default_nettype none
module hsecfg_sync2
  import hsecfg_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ### testbench/hsecfg_props.sv
/* Port checker for hsecfg_top.
   Assumes one mclk domain, bound to every hsecfg_top. */
`default_nettype none
module hsecfg_props
  import hsecfg_pkg::*;
(
  // Clock, reset and inputs
  input wire logic           mclk,
  input wire logic           nrst,
  input wire logic [3:0]     on_cmp,
  input wire logic [3:0]     crit_fault,
  input wire hsecfg_hostwr_t host_wr,
  // Outputs
  input wire logic [3:0]     software_enable_bit,
  input wire logic [3:0]     hardware_default_enable_bit,
  input wire logic [3:0]     on_status,
  input wire logic [3:0]     gate_drive,
  input wire logic           alert_out,
  input wire logic           config_loaded,
  input wire hsecfg_grp_t    grouping_mode,
  input wire hsecfg_protection_strap_pin_t   protection_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] age_r;
  logic       flt_r;
  logic [3:0] en_c;
  ////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!nrst) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  // Shutdown latch hides the plain gate relation
  always_ff @(posedge mclk) begin
    if (!nrst) flt_r <= 1'b0;
    else if (crit_fault != 4'h0) flt_r <= 1'b1;
  end
  assign en_c = on_status & (software_enable_bit | hardware_default_enable_bit);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_off_before_run: assert property (!config_loaded
    && $past(config_loaded) == 1'b0 |-> gate_drive == 4'h0)
    else $error("gate driven before run");
  a_gate_indep: assert property (config_loaded && $past(config_loaded)
    && !flt_r && grouping_mode == HSECFG_GRP_INDEP |-> gate_drive == $past(en_c))
    else $error("gate not on and enable");
  a_gate_paired: assert property (config_loaded && !flt_r
    && grouping_mode == HSECFG_GRP_PAIRED |-> gate_drive[0] == gate_drive[2]
    && gate_drive[1] == gate_drive[3]) else $error("pair split");
  a_gate_all: assert property (!flt_r && grouping_mode == HSECFG_GRP_ALL
    |-> gate_drive inside {4'h0, 4'hf}) else $error("group split");
  a_hw_write: assert property (host_wr.wr && config_loaded |=>
    hardware_default_enable_bit == (($past(host_wr.hw_en) & $past(host_wr.hw_mask))
    | ($past(hardware_default_enable_bit) & ~$past(host_wr.hw_mask))))
    else $error("hw enable write wrong");
  a_sw_write: assert property (host_wr.wr && config_loaded |=>
    software_enable_bit == $past(host_wr.sw_en)) else $error("sw write wrong");
  a_bits_hold: assert property (config_loaded && $past(config_loaded)
    && !$past(host_wr.wr) |-> $stable(hardware_default_enable_bit)
    && $stable(software_enable_bit)) else $error("enable bits moved");
  a_on_follow: assert property (age_r == 3'h7
    |-> on_status == $past(on_cmp, 3)) else $error("on status lag wrong");
  a_modes_kept: assert property (config_loaded && $past(config_loaded)
    |-> $stable(grouping_mode) && $stable(protection_mode))
    else $error("mode changed");
  a_alert_lvl: assert property (config_loaded && $past(config_loaded, 2)
    |-> alert_out == ($past(crit_fault, 2) != 4'h0)) else $error("alert wrong");
  c_write: cover property (host_wr.wr && config_loaded);
  c_all_on: cover property (grouping_mode == HSECFG_GRP_ALL && gate_drive == 4'hf);
  c_alert: cover property (alert_out);
endmodule
bind hsecfg_top hsecfg_props u_props (.mclk, .nrst, .on_cmp, .crit_fault,
  .host_wr, .software_enable_bit, .hardware_default_enable_bit, .on_status,
  .gate_drive, .alert_out, .config_loaded, .grouping_mode, .protection_mode);
`default_nettype wire

// ### testbench/hsecfg_host_model.sv
/* Host model: turns one-cycle requests into host_wr pulses.
   Assumes requests change just after the rising edge of mclk. */
`default_nettype none
module hsecfg_host_model
  import hsecfg_pkg::*;
(
  // Clock
  input  wire logic         mclk,
  // Bench request {sw_en, hw_en, hw_mask}
  input  wire logic         req,
  input  wire logic [11:0]  val,
  // Write port
  output var hsecfg_hostwr_t host_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_wr = '0;
  // Idle fields flip so stale data never reads as a write
  always @(posedge mclk) begin
    host_wr.wr <= req;
    host_wr[11:0] <= req ? val : ~host_wr[11:0];
  end
endmodule
`default_nettype wire

// ### testbench/tb_hsecfg_top.sv
/* Self-checking bench for hsecfg_top, three strap passes.
   Assumes the bound checker and the host model beside it. */
`default_nettype none
module tb_hsecfg_top;
  import hsecfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, sup = 0, es = 0, req = 0, al, cl;
  logic [3:0] on_c = 0, cf = 0, sw_o, hw_o, ons, gd, pgd, sw_m, hw_m;
  logic [11:0] val = 0;
  logic [31:0] r;
  hsecfg_tri_t gs = 0, ps = 0;
  hsecfg_mon_t [3:0] mon = '0, mo;
  hsecfg_hostwr_t hwr;
  hsecfg_grp_t gm;
  hsecfg_protection_strap_pin_t pm;
  int n_fail = 0, n_tests = 0, cyc = 0, seed, p;
  int gmap[3] = '{1, 0, 2};
  always #2 mclk = ~mclk;
  ////////////////////////////////////////
  hsecfg_host_model u_host (.mclk(mclk), .req(req), .val(val), .host_wr(hwr));
  hsecfg_top u_dut (.mclk(mclk), .nrst(nrst), .supply_good(sup),
    .on_cmp(on_c), .enable_strap_pin(es), .grouping_strap(gs),
    .protection_strap_pin(ps), .host_wr(hwr), .software_enable_bit(sw_o),
    .hardware_default_enable_bit(hw_o), .on_status(ons), .crit_fault(cf),
    .mon_in(mon), .gate_drive(gd), .power_good_drop(pgd), .alert_out(al),
    .config_loaded(cl), .grouping_mode(gm), .protection_mode(pm),
    .mon_out(mo));
  ////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic cmp(input logic [20:0] g, input logic [20:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] v);
    tk(1);
    val <= v;
    req <= 1'b1;
    tk(1);
    req <= 1'b0;
  endtask
  task automatic stop_test;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Expected gates from per-channel condition and grouping
  function automatic logic [3:0] xg(input int m, input logic [3:0] c);
    case (m)
      0: return c;
      1: return {c[1] & c[3], c[0] & c[2], c[1] & c[3], c[0] & c[2]};
      default: return {4{&c}};
    endcase
  endfunction
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    seed = 32'h8caa99fa;
    for (int i = 0; i < 3; i++) begin
      p = (i + 1) % 3;
      tk(1);
      nrst <= 1'b0;
      sup <= 1'b0;
      cf <= 4'h0;
      on_c <= 4'hf;
      es <= (i == 1);
      gs <= 3'h4 >> i;
      ps <= 3'h4 >> p;
      tk(3);
      nrst <= 1'b1;
      tk(12);
      #1 cmp(gd, 4'h0);
      tk(1);
      // Late strap changes must be ignored
      sup <= 1'b1;
      es <= (i != 1);
      gs <= 3'h1;
      ps <= 3'h2;
      tk(8);
      hw_m = (i == 1) ? 4'hf : 4'h0;
      #1 cmp(cl, 1'b1);
      cmp(hw_o, hw_m);
      cmp(gm, gmap[i]);
      cmp(pm, p);
      cmp(gd, xg(gmap[i], hw_m));
      repeat (12) begin
        r = $random(seed);
        tk(1);
        on_c <= r[15:12];
        wr(r[11:0]);
        sw_m = r[11:8];
        hw_m = (r[7:4] & r[3:0]) | (hw_m & ~r[3:0]);
        tk(6);
        #1 cmp(hw_o, hw_m);
        cmp(sw_o, sw_m);
        cmp(ons, r[15:12]);
        cmp(gd, xg(gmap[i], r[15:12] & (sw_m | hw_m)));
      end
      tk(1);
      on_c <= 4'hf;
      wr(12'hf00);
      tk(6);
      r = $random(seed);
      mon[0] <= {1'b1, r[19:0]};
      tk(1);
      mon[0] <= '0;
      #1 cmp(mo[0], {1'b1, r[19:0]});
      tk(1);
      cf <= 4'h1;
      tk(4);
      #1 cmp(al, 1'b1);
      cmp(pgd[0], p != 2);
      cmp(gd[0], p != 1);
      $display("pass %0d done", i);
    end
    stop_test();
  end
endmodule
`default_nettype wire
